// ### shared/timing_nco_pkg.sv
/*
  timing_nco_pkg: register map, field positions, reset values and widths
  for the timing oscillator control block.
  assumes: included by the control block and its accumulator datapath.
*/
package timing_nco_pkg;

  // ==========================================================
  // widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int FREQ_W = 32;
  localparam int PHASE_W = 8;

  // ==========================================================
  // register indices (word numbers) and byte addresses
  localparam int IDX_CONFIG = 11;
  localparam int IDX_FREQ_HOLD = 12;
  localparam int IDX_PHASE_HOLD = 13;
  localparam int IDX_FREQ_STROBE = 14;
  localparam int IDX_PHASE_STROBE = 15;
  localparam int IDX_ACTIVE_FREQ = 16;
  localparam int IDX_ACTIVE_PHASE = 17;
  localparam int IDX_ACCUM = 18;
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = ADDR_W'(IDX_CONFIG * 4);
  localparam logic [ADDR_W-1:0] ADDR_FREQ_HOLD = ADDR_W'(IDX_FREQ_HOLD * 4);
  localparam logic [ADDR_W-1:0] ADDR_PHASE_HOLD = ADDR_W'(IDX_PHASE_HOLD * 4);
  localparam logic [ADDR_W-1:0] ADDR_FREQ_STROBE =
    ADDR_W'(IDX_FREQ_STROBE * 4);
  localparam logic [ADDR_W-1:0] ADDR_PHASE_STROBE =
    ADDR_W'(IDX_PHASE_STROBE * 4);
  localparam logic [ADDR_W-1:0] ADDR_ACTIVE_FREQ =
    ADDR_W'(IDX_ACTIVE_FREQ * 4);
  localparam logic [ADDR_W-1:0] ADDR_ACTIVE_PHASE =
    ADDR_W'(IDX_ACTIVE_PHASE * 4);
  localparam logic [ADDR_W-1:0] ADDR_ACCUM = ADDR_W'(IDX_ACCUM * 4);

  // ==========================================================
  // configuration word fields
  localparam int CFG_LOAD_ON_UPDATE = 0;
  localparam int CFG_CLEAR_ACC = 1;
  localparam int CFG_OFFSET_EN = 2;
  localparam int CFG_OFFSET_WIDTH_LO = 3;
  localparam int CFG_EXT_SYNC_EN = 5;
  localparam logic [DATA_W-1:0] CFG_WRITE_MASK = 32'h0000_003F;
  localparam logic [DATA_W-1:0] PHASE_WRITE_MASK = 32'h0000_00FF;

  // offset frequency width codes
  localparam logic [1:0] OFS_WIDTH_8 = 2'h0;
  localparam logic [1:0] OFS_WIDTH_16 = 2'h1;
  localparam logic [1:0] OFS_WIDTH_24 = 2'h2;
  localparam logic [1:0] OFS_WIDTH_32 = 2'h3;

  // ==========================================================
  // reset values
  localparam logic [DATA_W-1:0] RST_CONFIG = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_FREQ = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RST_PHASE = 32'h0000_0000;
  localparam logic SYNC_IDLE = 1'b1;

endpackage : timing_nco_pkg

// ### verification/timing_nco_control_bench.sv
/* bench: register level tests of the timing oscillator control block.
   assumes: package compiled first; checker bound from its own file. */
`timescale 1ns/1ps
module timing_nco_control_bench
  import timing_nco_pkg::*;
;
  logic sys_clk = 0, rstn = 0, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic run = 0, one = 0, sync_req = 0, sample_en, external_sync_pin_b;
  logic [ADDR_W-1:0] avs_address = '0;
  logic [DATA_W-1:0] avs_writedata = '0, avs_readdata, rd_v;
  logic [FREQ_W-1:0] offset_freq = '0, active_freq, phase_acc, timing_phase;
  logic [PHASE_W-1:0] active_phase;
  logic [ADDR_W-1:0] ra [6] = '{ADDR_CONFIG, ADDR_FREQ_HOLD, ADDR_PHASE_HOLD,
    ADDR_ACTIVE_FREQ, ADDR_ACTIVE_PHASE, ADDR_ACCUM};
  int num_errors = 0;
  int tests_run = 0;

  // ========
  // block and its far side
  timing_nco_control timing_nco_control_inst (.sys_clk(sys_clk),
    .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .sample_en(sample_en),
    .external_sync_pin_b(external_sync_pin_b), .offset_freq(offset_freq),
    .active_freq(active_freq), .active_phase(active_phase),
    .phase_acc(phase_acc), .timing_phase(timing_phase));
  timing_nco_partner timing_nco_partner_inst (.sys_clk(sys_clk),
    .rstn(rstn), .run(run), .one(one), .sync_req(sync_req),
    .sample_en(sample_en), .external_sync_pin_b(external_sync_pin_b));

  // 100 mhz clock
  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  // ========
  // tasks
  task automatic chk(input string what, input logic [31:0] exp, got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one access held until waitrequest is sampled low; a hang is the
  // watchdog's to end
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd_v = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk($sformatf("word %h", a), exp, rd_v);
  endtask : rd
  // one sample pulse, then let the accumulator settle
  task automatic step();
    @(posedge sys_clk);
    one <= 1'b1;
    @(posedge sys_clk);
    one <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask : step
  task automatic sync();
    @(posedge sys_clk);
    sync_req <= 1'b1;
    @(posedge sys_clk);
    sync_req <= 1'b0;
    repeat (14) @(posedge sys_clk);
  endtask : sync
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_sim

  // ========
  // test sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    foreach (ra[i]) rd(ra[i], 32'h0000_0000);
    // holding writes reach active words only through strobes
    wr(ADDR_FREQ_HOLD, 32'h1234_5678);
    wr(ADDR_PHASE_HOLD, 32'hFFFF_FFA5);
    rd(ADDR_ACTIVE_FREQ, 32'h0000_0000);
    rd(ADDR_ACTIVE_PHASE, 32'h0000_0000);
    rd(ADDR_PHASE_HOLD, 32'h0000_00A5);
    wr(ADDR_FREQ_STROBE, 32'hFFFF_FFFF);
    wr(ADDR_PHASE_STROBE, 32'h0000_0000);
    repeat (2) @(posedge sys_clk);
    rd(ADDR_ACTIVE_FREQ, 32'h1234_5678);
    rd(ADDR_ACTIVE_PHASE, 32'h0000_00A5);
    // read-only, strobe and unmapped places
    wr(ADDR_ACTIVE_FREQ, 32'h0000_0001);
    rd(ADDR_ACTIVE_FREQ, 32'h1234_5678);
    rd(ADDR_FREQ_STROBE, 32'h0000_0000);
    rd(8'h80, 32'h0000_0000);
    // sync pin ignored while disabled
    wr(ADDR_FREQ_HOLD, 32'h0000_0100);
    wr(ADDR_PHASE_HOLD, 32'h0000_003C);
    sync();
    rd(ADDR_ACTIVE_FREQ, 32'h1234_5678);
    step();
    rd(ADDR_ACCUM, 32'h1234_5678);
    // enabled sync with load on update zeroes the feedback
    wr(ADDR_CONFIG, 32'hFFFF_FFE1);
    rd(ADDR_CONFIG, 32'h0000_0021);
    sync();
    rd(ADDR_ACTIVE_FREQ, 32'h0000_0100);
    rd(ADDR_ACTIVE_PHASE, 32'h0000_013C);
    step();
    rd(ADDR_ACCUM, 32'h0000_0100);
    // frequency strobe with load on update
    wr(ADDR_CONFIG, 32'h0000_0001);
    wr(ADDR_FREQ_HOLD, 32'h0000_0010);
    wr(ADDR_FREQ_STROBE, 32'h0000_0000);
    repeat (2) @(posedge sys_clk);
    rd(ADDR_ACTIVE_PHASE, 32'h0000_013C);
    step();
    rd(ADDR_ACCUM, 32'h0000_0010);
    chk("timing phase", 32'h3C00_0010, timing_phase);
    // clear bit, offset gate and every offset width
    offset_freq <= 32'h89AB_CDEF;
    wr(ADDR_CONFIG, 32'h0000_0002);
    step();
    step();
    rd(ADDR_ACCUM, 32'h0000_0010);
    for (int w = 0; w < 4; w++) begin
      wr(ADDR_CONFIG, 32'h0000_0006 | (w << 3));
      step();
      rd(ADDR_ACCUM, 32'h0000_0010 +
        (32'h89AB_CDEF & (32'hFFFF_FFFF << (24 - 8 * w))));
    end
    // free running at a quarter of the input rate, first with the full 32-bit offset added, then without it
    wr(ADDR_FREQ_HOLD, 32'h4000_0000);
    wr(ADDR_FREQ_STROBE, 32'h0000_0000);
    wr(ADDR_CONFIG, 32'h0000_001C);
    run <= 1'b1;
    repeat (60) @(posedge sys_clk);
    wr(ADDR_CONFIG, 32'h0000_0000);
    repeat (60) @(posedge sys_clk);
    run <= 1'b0;
    end_sim();
  end

  // watchdog against a hung access
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    end_sim();
  end
endmodule : timing_nco_control_bench

// ### verification/timing_nco_control_chk.sv
/* checker: bus, transfer and accumulator relations at the top ports.
   assumes: bound to timing_nco_control; byteenable is always full. */
`timescale 1ns/1ps
module timing_nco_control_chk
  import timing_nco_pkg::*;
#(
  parameter int ACC_W = FREQ_W,
  parameter int PH_W = PHASE_W
) (
  // clock, reset and bus
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [DATA_W-1:0] avs_readdata,
  input wire logic avs_waitrequest,
  // pins and oscillator state
  input wire logic external_sync_pin_b,
  input wire logic sample_en,
  input wire logic [ACC_W-1:0] offset_freq,
  input wire logic [ACC_W-1:0] active_freq,
  input wire logic [PH_W-1:0] active_phase,
  input wire logic [ACC_W-1:0] phase_acc,
  input wire logic [ACC_W-1:0] timing_phase
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // ========
  // shadow words and transfer history
  logic wr, fs, ps, fell_en, pin_r;
  logic [5:0] cfg_r, sy_r;
  logic [2:0] fs_r, ps_r;
  logic [ACC_W-1:0] freq_r, ofs;
  logic [PH_W-1:0] ph_r;
  assign wr = avs_write & !avs_waitrequest;
  assign fs = wr && avs_address == ADDR_FREQ_STROBE;
  assign ps = wr && avs_address == ADDR_PHASE_STROBE;
  assign fell_en = pin_r & !external_sync_pin_b & cfg_r[5];
  assign ofs = cfg_r[2] ? offset_freq & ('1 << (8 * (3 - cfg_r[4:3]))) : '0;

  // follow accepted writes and recent transfers
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      cfg_r <= '0;
      freq_r <= '0;
      ph_r <= '0;
    end else if (wr && avs_address == ADDR_CONFIG) begin
      cfg_r <= avs_writedata[5:0];
    end else if (wr && avs_address == ADDR_FREQ_HOLD) begin
      freq_r <= avs_writedata;
    end else if (wr && avs_address == ADDR_PHASE_HOLD) begin
      ph_r <= avs_writedata[PH_W-1:0];
    end
    pin_r <= !rstn | external_sync_pin_b;
    fs_r <= rstn ? {fs_r[1:0], fs} : '0;
    ps_r <= rstn ? {ps_r[1:0], ps} : '0;
    sy_r <= rstn ? {sy_r[4:0], fell_en} : '0;
  end

  // ========
  // assertions
  a_bus_wait: assert property ((avs_read | avs_write) &&
    !$past(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus access not one wait state");
  a_freq_strobe: assert property (
    fs |-> ##[2:3] active_freq == freq_r)
    else $error("frequency strobe did not load");
  a_phase_strobe: assert property (
    ps |-> ##[2:3] active_phase == ph_r)
    else $error("phase strobe did not load");
  a_freq_held: assert property (
    $changed(active_freq) |-> |fs_r || |sy_r)
    else $error("active frequency changed alone");
  a_phase_held: assert property (
    $changed(active_phase) |-> |ps_r || |sy_r)
    else $error("active phase changed alone");
  a_sync_load: assert property (fell_en |-> ##[3:6]
    active_freq == freq_r && active_phase == ph_r)
    else $error("sync did not load held words");
  a_acc_idle: assert property (!sample_en |=> $stable(phase_acc))
    else $error("accumulator moved without sample");
  a_acc_clear: assert property (
    sample_en && cfg_r[1] && $stable(cfg_r)
    |=> phase_acc == $past(active_freq) + $past(ofs))
    else $error("cleared accumulator wrong");
  a_acc_add: assert property (
    sample_en && cfg_r[1:0] == 2'h0 && cfg_r == $past(cfg_r, 8) |=>
    phase_acc == $past(phase_acc) + $past(active_freq) + $past(ofs))
    else $error("accumulator sum wrong");
  a_timing_sum: assert property (timing_phase == $past(phase_acc) +
    {$past(active_phase), {(ACC_W - PH_W){1'b0}}})
    else $error("timing phase wrong");
  c_sync: cover property (fell_en);
  c_lou_strobe: cover property (fs && cfg_r[0]);
  c_wide_ofs: cover property (sample_en && cfg_r[2] && cfg_r[4:3] == 2'h3);
endmodule : timing_nco_control_chk

bind timing_nco_control timing_nco_control_chk #(.ACC_W(ACC_W), .PH_W(PH_W))
  chk_inst (.sys_clk(sys_clk), .rstn(rstn), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .sample_en(sample_en),
  .external_sync_pin_b(external_sync_pin_b), .offset_freq(offset_freq),
  .active_freq(active_freq), .active_phase(active_phase),
  .phase_acc(phase_acc), .timing_phase(timing_phase));

// ### verification/timing_nco_partner.sv
/* partner: sample pacing and external sync source facing the block.
   assumes: requests come from the bench on sys_clk. */
`timescale 1ns/1ps
module timing_nco_partner (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // requests from the bench
  input wire logic run,
  input wire logic one,
  input wire logic sync_req,
  // pins toward the block
  output logic sample_en,
  output logic external_sync_pin_b
);
  logic [1:0] div_r;
  logic [3:0] low_r;
  // one sample per request, or every fourth cycle while running
  always_ff @(posedge sys_clk) begin
    div_r <= rstn ? div_r + 2'h1 : 2'h0;
    sample_en <= rstn && (one || (run && div_r == 2'h3));
  end
  // sync pin pulled low for eight cycles, idle high otherwise
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      low_r <= 4'h0;
    end else if (sync_req) begin
      low_r <= 4'h8;
    end else if (low_r != 4'h0) begin
      low_r <= low_r - 4'h1;
    end
  end
  assign external_sync_pin_b = (low_r == 4'h0);
endmodule : timing_nco_partner

// ### verilog/timing_nco_accum.sv
/*
  timing_nco_accum: phase accumulator of the timing oscillator, with
  feedback zeroing and phase offset addition.
  assumes: all inputs come from logic on sys_clk.
*/
`timescale 1ns/1ps
module timing_nco_accum
  import timing_nco_pkg::*;
#(
  parameter int ACC_W = 32,
  parameter int PH_W = 8
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // sample pacing and controls
  input wire logic sample_en,
  input wire logic clear_acc,
  input wire logic zero_req,
  // increments and offset
  input wire logic [ACC_W-1:0] center_freq,
  input wire logic [ACC_W-1:0] offset_freq,
  input wire logic [PH_W-1:0] phase_offset,
  // results
  output logic [ACC_W-1:0] acc_r,
  output logic [ACC_W-1:0] timing_r,
  output logic zero_pend_r
);

  // ==========================================================
  // feedback path
  logic [ACC_W-1:0] feedback;
  logic [ACC_W-1:0] acc_nxt;

  // zeroed while clearing or while a one-shot zero is owed
  assign feedback = (clear_acc || zero_pend_r || zero_req) ?
                    '0 : acc_r; // see RL5
  assign acc_nxt = feedback + center_freq + offset_freq; // see RL14

  // one-shot zero waits for the next sample; a new request wins
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      zero_pend_r <= 1'b0;
    end else if (zero_req) begin
      zero_pend_r <= 1'b1; // see RL3
    end else if (sample_en) begin
      zero_pend_r <= 1'b0;
    end
  end

  // accumulate once per resampler input sample
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      acc_r <= '0;
    end else if (sample_en) begin
      acc_r <= acc_nxt; // see RL14
    end
  end

  // phase offset weights the top bits: one full period spans PH_W bits
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      timing_r <= '0;
    end else begin
      timing_r <= acc_r + {phase_offset, {(ACC_W-PH_W){1'b0}}}; // see RL10
    end
  end

endmodule : timing_nco_accum

// ### verilog/timing_nco_control.sv
/*
  timing_nco_control: control registers and update logic of the timing
  oscillator that paces the resampling filter, with an Avalon-MM slave.
  assumes: one clock, sys_clk, serves as processing clock; the external
  sync pin is asynchronous and active low; sample_en and offset_freq come
  from logic on sys_clk.

  // Summary of operation
  // RL1 - external sync pin is ignored while config bit 5 is zero
  // RL2 - with bit 5 set, sync asserts copy both held values to active
  // RL3 - with bit 0 set, a sync transfer also zeroes accumulator feedback
  // RL4 - bit 2 gates offset frequency; bits 4-3 pick 8,16,24,32 bits
  // RL5 - while bit 1 is set accumulator feedback is forced to zero
  // RL6 - with bit 0 set, a frequency strobe write also zeroes feedback
  // RL7 - software programs frequency as output over input rate times 2^32
  // RL8 - frequency writes land in holding; active changes only on transfer
  // RL9 - any write to the frequency strobe moves held frequency to active
  // RL10 - 8-bit phase offset spans one input period, signed or offset
  // RL11 - phase writes land in holding; active changes only on transfer
  // RL12 - any write to the phase strobe moves held phase to active
  // RL13 - all control words are retimed into processing clock first
  // RL14 - per sample, accumulator adds centre plus offset; phase added after
*/
`timescale 1ns/1ps
module timing_nco_control
  import timing_nco_pkg::*;
#(
  parameter int ACC_W = FREQ_W,
  parameter int PH_W = PHASE_W
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // external sync pin, active low
  input wire logic external_sync_pin_b,
  // resampler pacing and offset frequency from the tracking loop
  input wire logic sample_en,
  input wire logic [ACC_W-1:0] offset_freq,
  // oscillator state
  output logic [ACC_W-1:0] active_freq,
  output logic [PH_W-1:0] active_phase,
  output logic [ACC_W-1:0] phase_acc,
  output logic [ACC_W-1:0] timing_phase
);

  // ==========================================================
  // bus handshake
  logic ack_r;
  logic req;
  logic wr_go;
  logic [DATA_W-1:0] readdata_r;
  logic [DATA_W-1:0] rd_nxt;
  logic [DATA_W-1:0] be_mask;

  assign req = avs_read || avs_write;
  // one wait cycle: request seen, then answered on the following edge
  assign avs_waitrequest = req && !ack_r;
  assign wr_go = avs_write && ack_r;
  assign avs_readdata = readdata_r;

  // acknowledge toggles so a held request is answered once per beat
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req && !ack_r;
    end
  end

  // byte lane mask from byteenable
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign be_mask[8*gi +: 8] = {8{avs_byteenable[gi]}};
    end
  endgenerate

  // ==========================================================
  // software registers
  logic [DATA_W-1:0] config_r;
  logic [DATA_W-1:0] freq_hold_r;
  logic [DATA_W-1:0] phase_hold_r;
  logic wr_config;
  logic wr_freq_hold;
  logic wr_phase_hold;
  logic wr_freq_strobe;
  logic wr_phase_strobe;

  // address decode of the accepted write
  assign wr_config = wr_go && (avs_address == ADDR_CONFIG);
  assign wr_freq_hold = wr_go && (avs_address == ADDR_FREQ_HOLD);
  assign wr_phase_hold = wr_go && (avs_address == ADDR_PHASE_HOLD);
  assign wr_freq_strobe = wr_go && (avs_address == ADDR_FREQ_STROBE);
  assign wr_phase_strobe = wr_go && (avs_address == ADDR_PHASE_STROBE);

  // configuration word, reserved bits stay zero
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      config_r <= RST_CONFIG;
    end else if (wr_config) begin
      config_r <= ((config_r & ~be_mask) | (avs_writedata & be_mask)) &
                  CFG_WRITE_MASK;
    end
  end

  // centre frequency holding register only
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      freq_hold_r <= RST_FREQ;
    end else if (wr_freq_hold) begin
      freq_hold_r <= (freq_hold_r & ~be_mask) |
                     (avs_writedata & be_mask); // see RL8
    end
  end

  // phase offset holding register only
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      phase_hold_r <= RST_PHASE;
    end else if (wr_phase_hold) begin
      phase_hold_r <= ((phase_hold_r & ~be_mask) |
                       (avs_writedata & be_mask)) &
                      PHASE_WRITE_MASK; // see RL11
    end
  end

  // ==========================================================
  // retiming into the processing side
  logic [DATA_W-1:0] config_proc_r;
  logic freq_stb_r;
  logic phase_stb_r;

  // configuration copy that the oscillator logic reads
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      config_proc_r <= RST_CONFIG;
    end else begin
      config_proc_r <= config_r; // see RL13
    end
  end

  // strobe writes become one-cycle pulses; write data is ignored
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      freq_stb_r <= 1'b0;
      phase_stb_r <= 1'b0;
    end else begin
      freq_stb_r <= wr_freq_strobe; // see RL9
      phase_stb_r <= wr_phase_strobe; // see RL12
    end
  end

  // ==========================================================
  // external sync pin
  logic sync_meta_r;
  logic sync_r;
  logic sync_prev_r;
  logic sync_assert;
  logic ext_load;

  // two flip-flops against metastability, then one for edge detection
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sync_meta_r <= SYNC_IDLE;
      sync_r <= SYNC_IDLE;
      sync_prev_r <= SYNC_IDLE;
    end else begin
      sync_meta_r <= external_sync_pin_b;
      sync_r <= sync_meta_r; // see RL13
      sync_prev_r <= sync_r;
    end
  end

  // assertion is the falling edge of the active-low pin
  assign sync_assert = sync_prev_r && !sync_r;
  // pin has no effect unless enabled
  assign ext_load = sync_assert &&
                    config_proc_r[CFG_EXT_SYNC_EN]; // see RL1

  // ==========================================================
  // active registers
  logic [ACC_W-1:0] active_freq_r;
  logic [PH_W-1:0] active_phase_r;
  logic zero_req;

  // frequency moves on its strobe or an enabled sync
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      active_freq_r <= ACC_W'(RST_FREQ);
    end else if (freq_stb_r || ext_load) begin
      active_freq_r <= ACC_W'(freq_hold_r); // see RL2
    end
  end

  // phase offset moves on its strobe or an enabled sync
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      active_phase_r <= PH_W'(RST_PHASE);
    end else if (phase_stb_r || ext_load) begin
      active_phase_r <= PH_W'(phase_hold_r); // see RL2
    end
  end

  assign active_freq = active_freq_r;
  assign active_phase = active_phase_r;

  // load on update: frequency strobe or sync zeroes the feedback once
  assign zero_req = config_proc_r[CFG_LOAD_ON_UPDATE] &&
                    (freq_stb_r || ext_load); // see RL3, see RL6

  // ==========================================================
  // offset frequency width and enable
  logic [ACC_W-1:0] offset_sel;
  logic [1:0] ofs_width;

  assign ofs_width = config_proc_r[CFG_OFFSET_WIDTH_LO +: 2];

  // keep the top bits of the offset, zero the rest
  always_comb begin
    offset_sel = '0;
    if (config_proc_r[CFG_OFFSET_EN]) begin
      case (ofs_width)
        OFS_WIDTH_8: begin
          offset_sel = {offset_freq[ACC_W-1 -: 8], {(ACC_W-8){1'b0}}};
        end
        OFS_WIDTH_16: begin
          offset_sel = {offset_freq[ACC_W-1 -: 16], {(ACC_W-16){1'b0}}};
        end
        OFS_WIDTH_24: begin
          offset_sel = {offset_freq[ACC_W-1 -: 24], {(ACC_W-24){1'b0}}};
        end
        OFS_WIDTH_32: begin
          offset_sel = offset_freq;
        end
        default: begin
          offset_sel = '0;
        end
      endcase // see RL4
    end
  end

  // ==========================================================
  // accumulator datapath
  logic zero_pend;

  timing_nco_accum #(
    .ACC_W(ACC_W),
    .PH_W(PH_W)
  ) u_accum (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .sample_en(sample_en),
    .clear_acc(config_proc_r[CFG_CLEAR_ACC]), // see RL5
    .zero_req(zero_req),
    .center_freq(active_freq_r), // see RL14
    .offset_freq(offset_sel),
    .phase_offset(active_phase_r),
    .acc_r(phase_acc),
    .timing_r(timing_phase),
    .zero_pend_r(zero_pend)
  );

  // ==========================================================
  // read back
  // strobe locations and unmapped addresses read as zero
  always_comb begin
    rd_nxt = '0;
    case (avs_address)
      ADDR_CONFIG: begin
        rd_nxt = config_r;
      end
      ADDR_FREQ_HOLD: begin
        rd_nxt = freq_hold_r;
      end
      ADDR_PHASE_HOLD: begin
        rd_nxt = phase_hold_r;
      end
      ADDR_ACTIVE_FREQ: begin
        rd_nxt = DATA_W'(active_freq_r);
      end
      ADDR_ACTIVE_PHASE: begin
        rd_nxt = {23'h00_0000, zero_pend, active_phase_r};
      end
      ADDR_ACCUM: begin
        rd_nxt = DATA_W'(phase_acc);
      end
      default: begin
        rd_nxt = '0;
      end
    endcase
  end

  // read data is captured in the wait cycle and stands at the answer
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      readdata_r <= '0;
    end else if (avs_read && !ack_r) begin
      readdata_r <= rd_nxt;
    end
  end

endmodule : timing_nco_control
